// file: common/trr_map.svh
`ifndef TRR_MAP_SVH
`define TRR_MAP_SVH
// register selector values
`define TRR_PTR_RESULT 8'h00
`define TRR_PTR_CFG 8'h01
`define TRR_PTR_TLOW 8'h02
`define TRR_PTR_THIGH 8'h03
`define TRR_PTR_NV_CFG 8'h11
`define TRR_PTR_NV_TLOW 8'h12
`define TRR_PTR_NV_THIGH 8'h13
`define TRR_PTR_RST 8'h00
// result register
`define TRR_RESULT_RST 16'h0000
`define TRR_SIGN_BIT 15
// valid-bit masks per resolution_select code
`define TRR_RES_9B 2'h0
`define TRR_RES_10B 2'h1
`define TRR_RES_11B 2'h2
`define TRR_RES_12B 2'h3
`define TRR_MASK_9B 16'hff80
`define TRR_MASK_10B 16'hffc0
`define TRR_MASK_11B 16'hffe0
`define TRR_MASK_12B 16'hfff0
// fixed upper bits of the bus address byte, and the pin synchroniser width
`define TRR_ADDR_FIXED 4'h9
`define TRR_SYNC_W 5
`endif

// file: common/trr_pkg.sv
`default_nettype none
package trr_pkg;
  typedef enum logic [2:0] {
    TRR_ST_IDLE,
    TRR_ST_ADDR,
    TRR_ST_ACK,
    TRR_ST_WDATA,
    TRR_ST_TX,
    TRR_ST_MACK
  } trr_state_t;

  // finished conversion from the converter, same clock domain
  typedef struct packed {
    logic done;
    logic [15:0] measured_value_bits;
  } trr_conv_t;
endpackage : trr_pkg
`default_nettype wire

// file: verilog/trr_readout.sv
`include "trr_map.svh"
`default_nettype none
module trr_readout
  import trr_pkg::*;
#(
  parameter int RESULT_W = 16
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] strapped_address_pins,
  input wire logic [1:0] resolution_select,
  input wire logic shutdown_mode,
  input wire trr_conv_t conv_in,
  output logic conv_start,
  output logic [15:0] temperature_result,
  output logic [7:0] register_selector,
  output logic read_busy
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (RESULT_W != 16) begin : g_bad_width
    $error("trr_readout: RESULT_W must be 16");
  end

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  function automatic logic [15:0] res_mask(input logic [1:0] res);
    logic [15:0] m;
    m = `TRR_MASK_9B;
    unique case (res)
      `TRR_RES_9B: m = `TRR_MASK_9B;
      `TRR_RES_10B: m = `TRR_MASK_10B;
      `TRR_RES_11B: m = `TRR_MASK_11B;
      `TRR_RES_12B: m = `TRR_MASK_12B;
    endcase
    return m;
  endfunction : res_mask

  function automatic logic ptr_valid(input logic [7:0] p);
    return (p == `TRR_PTR_RESULT) || (p == `TRR_PTR_CFG) ||
           (p == `TRR_PTR_TLOW) || (p == `TRR_PTR_THIGH) ||
           (p == `TRR_PTR_NV_CFG) || (p == `TRR_PTR_NV_TLOW) ||
           (p == `TRR_PTR_NV_THIGH);
  endfunction : ptr_valid

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [`TRR_SYNC_W-1:0] pins_raw;
  logic [`TRR_SYNC_W-1:0] sync1_ff;
  logic [`TRR_SYNC_W-1:0] sync2_ff;
  assign pins_raw = {strapped_address_pins, sda_in, scl_in};

  genvar gi;
  for (gi = 0; gi < `TRR_SYNC_W; gi++) begin : g_sync
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        sync1_ff[gi] <= 1'b1;
        sync2_ff[gi] <= 1'b1;
      end else begin
        sync1_ff[gi] <= pins_raw[gi];
        sync2_ff[gi] <= sync1_ff[gi];
      end
    end
  end

  logic scl_d_ff;
  logic sda_d_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= sync2_ff[0];
      sda_d_ff <= sync2_ff[1];
    end
  end

  wire scl_s = sync2_ff[0];
  wire sda_s = sync2_ff[1];
  wire [2:0] addr_s = sync2_ff[4:2];
  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire start_cond = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_cond = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // ----------------------------------------------------------------
  // result register
  // ----------------------------------------------------------------
  logic [15:0] result_ff;
  logic read_busy_ff;
  // sign in bit 15 and left-justified data come from the converter;
  // only the masking below is ours
  wire [15:0] masked_value = conv_in.measured_value_bits &
    res_mask(resolution_select);
  // a skipped update is dropped, not held: the next conversion brings
  // fresher data anyway
  wire load_result = conv_in.done & ~read_busy_ff;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      result_ff <= `TRR_RESULT_RST;
    end else if (load_result) begin
      result_ff <= masked_value;
    end
  end

  // ----------------------------------------------------------------
  // power-up conversion in shutdown mode
  // ----------------------------------------------------------------
  logic boot_done_ff;
  logic conv_start_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      boot_done_ff <= 1'b0;
      conv_start_ff <= 1'b0;
    end else begin
      boot_done_ff <= 1'b1;
      conv_start_ff <= ~boot_done_ff & shutdown_mode;
    end
  end

  // ----------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------
  trr_state_t state_ff;
  logic [7:0] shreg_ff;
  logic [2:0] cnt_ff;
  logic got8_ff;
  logic rw_ff;
  logic first_ff;
  logic hi_ff;
  logic mack_ff;
  logic oe_ff;
  logic [7:0] ptr_ff;

  wire addr_match = shreg_ff[7:1] == {`TRR_ADDR_FIXED, addr_s};
  wire sel_result = ptr_ff == `TRR_PTR_RESULT;
  // other selections belong to registers outside this block; read as 0
  wire [7:0] byte_hi = sel_result ? result_ff[15:8] : 8'h00;
  wire [7:0] byte_lo = sel_result ? result_ff[7:0] : 8'h00;
  wire ptr_ok = first_ff & ptr_valid(shreg_ff);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= TRR_ST_IDLE;
      shreg_ff <= 8'h00;
      cnt_ff <= 3'h0;
      got8_ff <= 1'b0;
      rw_ff <= 1'b0;
      first_ff <= 1'b0;
      hi_ff <= 1'b0;
      mack_ff <= 1'b0;
      oe_ff <= 1'b0;
      ptr_ff <= `TRR_PTR_RST;
      read_busy_ff <= 1'b0;
    end else if (stop_cond) begin
      state_ff <= TRR_ST_IDLE;
      oe_ff <= 1'b0;
      read_busy_ff <= 1'b0;
    end else if (start_cond) begin
      state_ff <= TRR_ST_ADDR;
      cnt_ff <= 3'h0;
      got8_ff <= 1'b0;
      oe_ff <= 1'b0;
      read_busy_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        TRR_ST_IDLE: begin
          oe_ff <= 1'b0;
        end
        TRR_ST_ADDR, TRR_ST_WDATA: begin
          if (scl_rise) begin
            shreg_ff <= {shreg_ff[6:0], sda_s};
            cnt_ff <= cnt_ff + 3'h1;
            got8_ff <= cnt_ff == 3'h7;
          end else if (scl_fall && got8_ff) begin
            got8_ff <= 1'b0;
            if (state_ff == TRR_ST_ADDR) begin
              if (addr_match) begin
                oe_ff <= 1'b1;
                rw_ff <= shreg_ff[0];
                first_ff <= ~shreg_ff[0];
                read_busy_ff <= shreg_ff[0];
                state_ff <= TRR_ST_ACK;
              end else begin
                state_ff <= TRR_ST_IDLE;
              end
            end else begin
              // only a selector byte that ptr_valid accepts is acked; other selectors and data bytes are refused
              oe_ff <= ptr_ok;
              if (ptr_ok) begin
                ptr_ff <= shreg_ff;
              end
              first_ff <= 1'b0;
              state_ff <= TRR_ST_ACK;
            end
          end
        end
        TRR_ST_ACK: begin
          if (scl_fall) begin
            cnt_ff <= 3'h0;
            if (rw_ff) begin
              shreg_ff <= {byte_hi[6:0], 1'b0};
              oe_ff <= ~byte_hi[7];
              hi_ff <= 1'b1;
              state_ff <= TRR_ST_TX;
            end else begin
              oe_ff <= 1'b0;
              state_ff <= TRR_ST_WDATA;
            end
          end
        end
        TRR_ST_TX: begin
          if (scl_fall) begin
            if (cnt_ff == 3'h7) begin
              oe_ff <= 1'b0;
              state_ff <= TRR_ST_MACK;
            end else begin
              cnt_ff <= cnt_ff + 3'h1;
              oe_ff <= ~shreg_ff[7];
              shreg_ff <= {shreg_ff[6:0], 1'b0};
            end
          end
        end
        TRR_ST_MACK: begin
          if (scl_rise) begin
            mack_ff <= ~sda_s;
          end else if (scl_fall) begin
            cnt_ff <= 3'h0;
            if (mack_ff && hi_ff) begin
              shreg_ff <= {byte_lo[6:0], 1'b0};
              oe_ff <= ~byte_lo[7];
              hi_ff <= 1'b0;
              state_ff <= TRR_ST_TX;
            end else if (mack_ff) begin
              shreg_ff <= {byte_hi[6:0], 1'b0};
              oe_ff <= ~byte_hi[7];
              hi_ff <= 1'b1;
              state_ff <= TRR_ST_TX;
            end else begin
              // master nack: release the line, wait for stop or start
              oe_ff <= 1'b0;
              read_busy_ff <= 1'b0;
              state_ff <= TRR_ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic sda_out_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sda_out_ff <= 1'b0;
    end else begin
      sda_out_ff <= 1'b0;
    end
  end

  assign sda_out = sda_out_ff;
  assign sda_oe = oe_ff;
  assign conv_start = conv_start_ff;
  assign temperature_result = result_ff;
  assign register_selector = ptr_ff;
  assign read_busy = read_busy_ff;

endmodule : trr_readout
`default_nettype wire

// file: dv/trr_readout_assertions.sv
`default_nettype none
module trr_readout_assertions
  import trr_pkg::*;
#(
  parameter int RESULT_W = 16
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [2:0] strapped_address_pins,
  input wire logic [1:0] resolution_select,
  input wire logic shutdown_mode,
  input wire trr_conv_t conv_in,
  input wire logic conv_start,
  input wire logic [15:0] temperature_result,
  input wire logic [7:0] register_selector,
  input wire logic read_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // --
  // checks
  // --
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  sequence s_load;
    conv_in.done && !read_busy;
  endsequence
  a_load_masked: assert property (s_load |=>
    temperature_result == ($past(conv_in.measured_value_bits)
    & (16'hffff << (7 - $past(resolution_select)))))
    else $error("load not masked");
  a_skip_busy: assert property (
    conv_in.done && read_busy |=> $stable(temperature_result))
    else $error("update during read");
  a_hold_idle: assert property (
    !conv_in.done |=> $stable(temperature_result))
    else $error("result moved");
  a_low_nibble: assert property (temperature_result[3:0] == 4'h0)
    else $error("low bits set");
  a_reset_vals: assert property ($rose(arst_n) |->
    temperature_result == 16'h0000 && register_selector == 8'h00)
    else $error("reset values");
  a_startup_conv: assert property (
    $rose(arst_n) |=> conv_start == $past(shutdown_mode))
    else $error("startup conversion");
  a_conv_once: assert property (conv_start |=> !conv_start [*8])
    else $error("second conversion");
  a_ack_busy: assert property ($rose(read_busy) |-> sda_oe)
    else $error("read without ack");
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("sda driven high");
endmodule : trr_readout_assertions
`default_nettype wire

// file: dv/trr_i2c_master.sv
`default_nettype none
module trr_i2c_master (
  input wire logic clock,
  output logic scl,
  output logic pull_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // --
  // bus master, scl idles high between frames
  // --
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  // every bus change lands just after a clock edge, whatever the caller
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic start;
    tick(2);
    pull_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    pull_low = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask : start
  task automatic xfer(input logic b, output logic r);
    tick(2);
    pull_low = ~b;
    tick(2);
    scl = 1'b1;
    tick(2);
    r = sda;
    tick(2);
    scl = 1'b0;
  endtask : xfer
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(d[i], r);
    xfer(1'b1, r);
    ack = ~r;
  endtask : put
  // the ninth bit is the master's own answer, kept out of the data byte
  task automatic get(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
    xfer(~ack, r);
  endtask : get
  task automatic stop;
    tick(2);
    pull_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    pull_low = 1'b0;
    tick(4);
  endtask : stop
endmodule : trr_i2c_master
`default_nettype wire

// file: dv/tb_top.sv
`default_nettype none
module tb_top
  import trr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] STRAP = 3'h5;
  logic clock, arst_n, shutdown_mode, sda_oe, sda_out, scl, pull_low;
  logic read_busy, conv_start, a;
  logic [1:0] res;
  logic [15:0] result;
  logic [7:0] sel, hi, lo, again;
  trr_conv_t conv_in;
  wire logic sda = ~(sda_oe | pull_low);
  int err_count, n_compared, starts;
  trr_readout i_dut (.clock(clock), .arst_n(arst_n), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .strapped_address_pins(STRAP), .resolution_select(res),
    .shutdown_mode(shutdown_mode), .conv_in(conv_in),
    .conv_start(conv_start), .temperature_result(result),
    .register_selector(sel), .read_busy(read_busy));
  trr_i2c_master i_mst (.clock(clock), .scl(scl), .pull_low(pull_low),
    .sda(sda));
  // --
  // helpers
  // --
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic give_verdict;
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic conv(input logic [15:0] v);
    conv_in = '{1'b1, v};
    @(posedge clock) #1;
    conv_in.done = 1'b0;
    @(posedge clock) #1;
  endtask : conv
  // --
  // scenarios
  // --
  task automatic t_reset;
    chk("result", 16'h0000, result);
    chk("selector", 16'h0000, {8'h00, sel});
    chk("conversions", 16'h0001, 16'(starts));
  endtask : t_reset
  task automatic t_res;
    for (int r = 0; r < 4; r++) begin
      res = 2'(r);
      conv(16'hc9af);
      chk("masked", 16'hc9af & (16'hffff << (7 - r)), result);
    end
  endtask : t_res
  task automatic t_read16;
    conv(16'h7d0f);
    i_mst.start();
    i_mst.put({4'h9, STRAP, 1'b1}, a);
    chk("addr ack", 16'h0001, {15'h0, a});
    i_mst.get(1'b1, hi);
    conv(16'h0010);
    i_mst.get(1'b1, lo);
    i_mst.get(1'b0, again);
    i_mst.stop();
    chk("read", 16'h7d00, {hi, lo});
    chk("again", 16'h007d, {8'h00, again});
    chk("kept", 16'h7d00, result);
    conv(16'h0010);
    chk("step", 16'h0010, result);
  endtask : t_read16
  task automatic t_read8;
    conv(16'hfff0);
    i_mst.start();
    i_mst.put({4'h9, STRAP, 1'b1}, a);
    i_mst.get(1'b0, hi);
    chk("upper", 16'h00ff, {8'h00, hi});
    chk("whole deg", 16'hffff, {{8{hi[7]}}, hi});
    i_mst.stop();
    chk("busy", 16'h0000, {15'h0, read_busy});
  endtask : t_read8
  task automatic t_write;
    i_mst.start();
    i_mst.put({4'h9, ~STRAP, 1'b1}, a);
    chk("foreign", 16'h0000, {15'h0, a});
    i_mst.start();
    i_mst.put({4'h9, STRAP, 1'b0}, a);
    i_mst.put(8'h00, a);
    chk("sel ack", 16'h0001, {15'h0, a});
    i_mst.put(8'h5a, a);
    chk("data nack", 16'h0000, {15'h0, a});
    i_mst.stop();
    chk("unwritten", 16'hfff0, result);
  endtask : t_write
  task automatic t_midreset;
    int s0;
    i_mst.start();
    i_mst.put({4'h9, STRAP, 1'b0}, a);
    i_mst.put(8'h01, a);
    i_mst.stop();
    chk("sel moved", 16'h0001, {8'h00, sel});
    i_mst.start();
    i_mst.put({4'h9, STRAP, 1'b1}, a);
    i_mst.get(1'b0, hi);
    i_mst.stop();
    chk("other reg", 16'h0000, {8'h00, hi});
    s0 = starts;
    shutdown_mode = 1'b0;
    arst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    chk("result", 16'h0000, result);
    chk("selector", 16'h0000, {8'h00, sel});
    chk("conversions", 16'(s0), 16'(starts));
  endtask : t_midreset
  // --
  // run
  // --
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) if (conv_start === 1'b1) starts++;
  initial begin
    arst_n = 1'b0;
    shutdown_mode = 1'b1;
    res = 2'h3;
    conv_in = '{1'b0, 16'h0000};
    repeat (4) @(posedge clock);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge clock);
    #1 t_reset();
    t_res();
    t_read16();
    t_read8();
    t_write();
    t_midreset();
    give_verdict();
  end
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
endmodule : tb_top
bind trr_readout trr_readout_assertions #(.RESULT_W(RESULT_W)) i_chk (
  .clock(clock), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .conv_in(conv_in),
  .strapped_address_pins(strapped_address_pins),
  .resolution_select(resolution_select), .shutdown_mode(shutdown_mode),
  .conv_start(conv_start), .temperature_result(temperature_result),
  .register_selector(register_selector), .read_busy(read_busy));
`default_nettype wire
